/* src/pll_synth_config_regs.svh */
// field positions, select codes, reset values and lock counts
// assumes 32-bit serial words with the select code in the low bits
`ifndef PLL_SYNTH_CONFIG_REGS_SVH
`define PLL_SYNTH_CONFIG_REGS_SVH
`define WORD_W 32
`define WORD_RST 32'h0000_0000
`define SEL_MSB 2
`define SEL_R0 3'h0
`define SEL_R1 3'h1
`define SEL_R2 3'h2
`define SEL_R3 3'h3
`define SEL_R4 3'h4
`define FRACTION_NUMERATOR_MSB 14
`define FRACTION_NUMERATOR_LSB 3
`define MOD_MSB 14
`define MOD_LSB 3
`define PHASE_MSB 26
`define PHASE_LSB 15
`define PRESC_BIT 27
`define NOISE_MSB 30
`define NOISE_LSB 29
`define MUX_MSB 28
`define MUX_LSB 26
`define DOUBLER_BIT 25
`define HALVER_BIT 24
`define RCNT_MSB 23
`define RCNT_LSB 14
`define DBUF_BIT 13
`define CP_MSB 11
`define CP_LSB 9
`define LDF_BIT 8
`define LDP_BIT 7
`define PD_BIT 5
`define CP3_BIT 4
`define CRST_BIT 3
`define BOOST_BIT 18
`define ODIV_MSB 22
`define ODIV_LSB 20
`define LOCK_CYCLES_LONG 6'h28
`define LOCK_CYCLES_SHORT 6'h05
`define LOCK_WIN_WIDE_NS 8'h0a
`define LOCK_WIN_NARROW_NS 8'h06
`endif

/* src/pll_synth_pkg.sv */
// shared types of the synthesizer configuration logic
// assumes nothing of its surroundings
package pll_synth_pkg;
  typedef logic [11:0] word12_t;
  typedef logic [9:0] rcount_t;
  typedef logic [5:0] lock_count_t;
  typedef enum logic [1:0] {
    LK_IDLE = 2'h0,
    LK_COUNT = 2'h1,
    LK_LOCKED = 2'h3
  } lock_state_t;
endpackage

/* src/pll_synth_config_regs.sv */
// configuration registers, reference path and lock detect of the synthesizer
// assumes a host shifting 32-bit words msb first on serial_clk, then
// pulsing latch_enable with serial_clk standing still
`timescale 1ns/10ps
`default_nettype none
`include "pll_synth_config_regs.svh"

// Contract
// - fraction numerator comes from bits 14..3 of the integer/fraction word.
// - select codes 001, 010, 011 route the word to registers 1, 2, 3.
// - bit 27 of register 1 picks prescaler 4/5 or 8/9.
// - fraction modulus comes from bits 14..3 of register 1.
// - bits 30..29 of register 2 pick noise mode; low spur enables dither.
// - bits 28..26 of register 2 select the test multiplexer source.
// - bit 25 of register 2 doubles the reference into the R counter.
// - bit 24 of register 2 adds a toggle stage after the R counter.
// - R counter divides the reference by bits 23..14, 1 to 1023.
// - bit 13 of register 2 enables double buffering of divider select.
// - double buffered fields take effect at the next register 0 write.
// - divider select waits for register 0 only when buffering is on.
// - bits 11..9 of register 2 set the charge pump current code.
// - lock detect counts 40 cycles, or 5 when bit 8 is set.
// - lock window is 10 ns, or 6 ns when bit 7 is set.
// - lock asserts after that many consecutive cycles below the window.
// - bit 5 of register 2 powers down; register contents are kept.
// - power-down loads counters, tristates pump, clears lock, stops outputs.
// - bit 4 of register 2 forces the charge pump into three-state.
// - bit 3 of register 2 holds R and N counters in reset.
// - bit 18 of register 3 enables charge pump boost.
module pll_synth_config_regs #(
  parameter logic [1:0] LOW_SPUR_CODE = 2'h3
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_enable,
  input wire logic ref_rise,
  input wire logic ref_fall,
  input wire logic pfd_cycle,
  input wire logic [7:0] phase_error_ns,
  output logic [11:0] fraction_numerator_q,
  output logic [11:0] fraction_modulus_q,
  output logic [11:0] phase_word_q,
  output logic prescaler_select_q,
  output logic [1:0] noise_mode_q,
  output logic dither_enable_q,
  output logic [2:0] test_mux_output_q,
  output logic doubler_enable_q,
  output logic reference_halver_q,
  output logic [9:0] r_count_q,
  output logic [2:0] cp_current_q,
  output logic lock_cycle_count_select_q,
  output logic lock_window_select_q,
  output logic power_down_bit_q,
  output logic cp_three_state_q,
  output logic counter_reset_q,
  output logic boost_enable_q,
  output logic [2:0] divider_select_q,
  output logic output_buffer_enable_q,
  output logic pfd_reference_q,
  output logic lock_detect_q
);

  // refuse header values that the fixed field and counter types cannot hold
  // these only guard edits of the header and cost no logic
  if (`NOISE_MSB >= `WORD_W || `PHASE_MSB >= `WORD_W) begin : g_chk_word
    $error("a field lies beyond the serial word");
  end
  if (`FRACTION_NUMERATOR_MSB - `FRACTION_NUMERATOR_LSB != 11) begin : g_chk_fraction_numerator
    $error("fraction field must be twelve bits wide");
  end
  if (`MOD_MSB - `MOD_LSB != 11) begin : g_chk_mod
    $error("modulus field must be twelve bits wide");
  end
  if (`PHASE_MSB - `PHASE_LSB != 11) begin : g_chk_phase
    $error("phase field must be twelve bits wide");
  end
  if (`RCNT_MSB - `RCNT_LSB != 9) begin : g_chk_rcount
    $error("r counter field must be ten bits wide");
  end
  if (`LOCK_CYCLES_SHORT == 0 || `LOCK_CYCLES_LONG == 0) begin : g_chk_lock
    $error("lock cycle counts must not be zero");
  end
  if (`LOCK_WIN_NARROW_NS == 0 || `LOCK_WIN_WIDE_NS == 0) begin : g_chk_window
    $error("lock windows must not be zero");
  end

  // link domain: shift register, frozen while the latch strobe is high
  // the word crosses to ref_clk without a handshake: the host keeps the
  // link clock still while the strobe is high, so the bits stand quietly
  logic [`WORD_W-1:0] shift_q;
  always_ff @(posedge serial_clk or posedge rst) begin
    if (rst) begin
      shift_q <= `WORD_RST;
    end else if (!latch_enable) begin
      shift_q <= {shift_q[`WORD_W-2:0], serial_data};
    end
  end

  // strobe synchroniser; third stage only feeds the edge detector
  // ce low freezes ref_clk state; the link shift register keeps running
  logic le_s1_q;
  logic le_s2_q;
  logic le_s3_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      le_s1_q <= 1'b0;
      le_s2_q <= 1'b0;
      le_s3_q <= 1'b0;
    end else if (ce) begin
      le_s1_q <= latch_enable;
      le_s2_q <= le_s1_q;
      le_s3_q <= le_s2_q;
    end
  end

  // shift_q is static while the strobe is high, so it is read safely here
  // a strobe shorter than one ref_clk period may be missed
  logic latch_evt;
  logic [`WORD_W-1:0] word;
  logic [`SEL_MSB:0] register_select_bits;
  logic wr0;
  logic wr1;
  logic wr2;
  logic wr3;
  logic wr4;
  assign latch_evt = ce && le_s2_q && !le_s3_q;
  assign word = shift_q;
  assign register_select_bits = word[`SEL_MSB:0];
  assign wr0 = latch_evt && (register_select_bits == `SEL_R0);
  assign wr1 = latch_evt && (register_select_bits == `SEL_R1);
  assign wr2 = latch_evt && (register_select_bits == `SEL_R2);
  assign wr3 = latch_evt && (register_select_bits == `SEL_R3);
  assign wr4 = latch_evt && (register_select_bits == `SEL_R4);

  // integer/fraction word: numerator plus the transfer of staged fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fraction_numerator_q <= 12'h000;
    end else if (wr0) begin
      fraction_numerator_q <= word[`FRACTION_NUMERATOR_MSB:`FRACTION_NUMERATOR_LSB];
    end
  end

  // staged copies of the double buffered fields
  pll_synth_pkg::word12_t phase_stage_q;
  pll_synth_pkg::word12_t modulus_stage_q;
  logic doubler_stage_q;
  logic halver_stage_q;
  pll_synth_pkg::rcount_t rcount_stage_q;
  logic [2:0] divsel_stage_q;
  logic double_buffer_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_stage_q <= 12'h000;
      modulus_stage_q <= 12'h000;
      prescaler_select_q <= 1'b0;
    end else if (wr1) begin
      phase_stage_q <= word[`PHASE_MSB:`PHASE_LSB];
      modulus_stage_q <= word[`MOD_MSB:`MOD_LSB];
      prescaler_select_q <= word[`PRESC_BIT];
    end
  end

  // register 2: immediate control bits and staged reference fields
  // power-down forcing is taken from the same word, so it follows bit 5
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      noise_mode_q <= 2'h0;
      dither_enable_q <= 1'b0;
      test_mux_output_q <= 3'h0;
      doubler_stage_q <= 1'b0;
      halver_stage_q <= 1'b0;
      rcount_stage_q <= 10'h001;
      double_buffer_q <= 1'b0;
      cp_current_q <= 3'h0;
      lock_cycle_count_select_q <= 1'b0;
      lock_window_select_q <= 1'b0;
      power_down_bit_q <= 1'b0;
      cp_three_state_q <= 1'b0;
      counter_reset_q <= 1'b0;
    end else if (wr2) begin
      noise_mode_q <= word[`NOISE_MSB:`NOISE_LSB];
      dither_enable_q <= word[`NOISE_MSB:`NOISE_LSB] == LOW_SPUR_CODE;
      test_mux_output_q <= word[`MUX_MSB:`MUX_LSB];
      doubler_stage_q <= word[`DOUBLER_BIT];
      halver_stage_q <= word[`HALVER_BIT];
      rcount_stage_q <= word[`RCNT_MSB:`RCNT_LSB];
      double_buffer_q <= word[`DBUF_BIT];
      cp_current_q <= word[`CP_MSB:`CP_LSB];
      lock_cycle_count_select_q <= word[`LDF_BIT];
      lock_window_select_q <= word[`LDP_BIT];
      power_down_bit_q <= word[`PD_BIT];
      cp_three_state_q <= word[`CP3_BIT] | word[`PD_BIT];
      counter_reset_q <= word[`CRST_BIT] | word[`PD_BIT];
    end
  end

  // register 3: boost enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boost_enable_q <= 1'b0;
    end else if (wr3) begin
      boost_enable_q <= word[`BOOST_BIT];
    end
  end

  // output buffers follow power-down, kept separately for a clean output
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      output_buffer_enable_q <= 1'b1;
    end else if (wr2) begin
      output_buffer_enable_q <= !word[`PD_BIT];
    end
  end

  // double buffered fields move to the active set on a register 0 write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_word_q <= 12'h000;
      fraction_modulus_q <= 12'h000;
      doubler_enable_q <= 1'b0;
      reference_halver_q <= 1'b0;
      r_count_q <= 10'h001;
    end else if (wr0) begin
      phase_word_q <= phase_stage_q;
      fraction_modulus_q <= modulus_stage_q;
      doubler_enable_q <= doubler_stage_q;
      reference_halver_q <= halver_stage_q;
      r_count_q <= rcount_stage_q;
    end
  end

  // divider select: staged while buffering is on, else applied at once
  // a staged value is kept if buffering is switched off before it lands
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divsel_stage_q <= 3'h0;
      divider_select_q <= 3'h0;
    end else begin
      if (wr4) begin
        divsel_stage_q <= word[`ODIV_MSB:`ODIV_LSB];
      end
      if (wr4 && !double_buffer_q) begin
        divider_select_q <= word[`ODIV_MSB:`ODIV_LSB];
      end else if (wr0 && double_buffer_q) begin
        divider_select_q <= divsel_stage_q;
      end
    end
  end

  // active reference edges: falling only, or both with the doubler
  logic ref_active;
  logic hold_counters;
  assign ref_active = ref_fall || (doubler_enable_q && ref_rise);
  assign hold_counters = counter_reset_q || power_down_bit_q;

  // R counter with optional toggle stage toward the phase detector
  // a ratio of zero behaves as a ratio of one
  pll_synth_pkg::rcount_t r_cnt_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r_cnt_q <= 10'h000;
      pfd_reference_q <= 1'b0;
    end else if (ce) begin
      if (hold_counters) begin
        r_cnt_q <= 10'h000;
        pfd_reference_q <= 1'b0;
      end else if (ref_active) begin
        if (r_cnt_q + 10'h001 >= r_count_q) begin
          r_cnt_q <= 10'h000;
          pfd_reference_q <= reference_halver_q ? !pfd_reference_q
                                                : 1'b1;
        end else begin
          r_cnt_q <= r_cnt_q + 10'h001;
          if (!reference_halver_q) begin
            pfd_reference_q <= 1'b0;
          end
        end
      end else if (!reference_halver_q) begin
        pfd_reference_q <= 1'b0;
      end
    end
  end

  // lock detect thresholds
  // the comparison is strict: an error equal to the window counts as bad
  pll_synth_pkg::lock_count_t lock_need;
  logic [7:0] lock_window;
  assign lock_need = lock_cycle_count_select_q ? `LOCK_CYCLES_SHORT
                                               : `LOCK_CYCLES_LONG;
  assign lock_window = lock_window_select_q ? `LOCK_WIN_NARROW_NS
                                            : `LOCK_WIN_WIDE_NS;

  // lock detector: counts consecutive good phase detector cycles
  // a change of the cycle select applies to the run already in progress
  pll_synth_pkg::lock_state_t lock_state_q;
  pll_synth_pkg::lock_count_t lock_cnt_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_state_q <= pll_synth_pkg::LK_IDLE;
      lock_cnt_q <= 6'h00;
      lock_detect_q <= 1'b0;
    end else if (ce) begin
      if (power_down_bit_q) begin
        lock_state_q <= pll_synth_pkg::LK_IDLE;
        lock_cnt_q <= 6'h00;
        lock_detect_q <= 1'b0;
      end else if (pfd_cycle) begin
        if (phase_error_ns >= lock_window) begin
          lock_state_q <= pll_synth_pkg::LK_COUNT;
          lock_cnt_q <= 6'h00;
          lock_detect_q <= 1'b0;
        end else begin
          case (lock_state_q)
            pll_synth_pkg::LK_LOCKED: begin
              lock_detect_q <= 1'b1;
            end
            default: begin
              if (lock_cnt_q + 6'h01 >= lock_need) begin
                lock_state_q <= pll_synth_pkg::LK_LOCKED;
                lock_detect_q <= 1'b1;
                lock_cnt_q <= 6'h00;
              end else begin
                lock_state_q <= pll_synth_pkg::LK_COUNT;
                lock_cnt_q <= lock_cnt_q + 6'h01;
              end
            end
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

/* bench/pll_synth_config_regs_monitor.sv */
// port checker of lock detect, power-down and register hold relations
// assumes binding onto pll_synth_config_regs, all in the ref_clk domain
`timescale 1ns/10ps
`default_nettype none
module pll_synth_config_regs_monitor #(
  parameter logic [1:0] LOW_SPUR_CODE = 2'h3
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic latch_enable,
  input wire logic pfd_cycle,
  input wire logic [7:0] phase_error_ns,
  input wire logic [11:0] fraction_modulus_q,
  input wire logic [1:0] noise_mode_q,
  input wire logic dither_enable_q,
  input wire logic [9:0] r_count_q,
  input wire logic lock_cycle_count_select_q,
  input wire logic lock_window_select_q,
  input wire logic power_down_bit_q,
  input wire logic cp_three_state_q,
  input wire logic counter_reset_q,
  input wire logic output_buffer_enable_q,
  input wire logic pfd_reference_q,
  input wire logic lock_detect_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic good;
  logic [5:0] run_q;
  // comparison inside the selected window
  assign good = phase_error_ns < (lock_window_select_q ? 8'h06 : 8'h0a);
  // run of consecutive good comparisons
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_q <= 6'h00;
    end else if (power_down_bit_q) begin
      run_q <= 6'h00;
    end else if (pfd_cycle && ce) begin
      run_q <= good ? run_q + {5'h00, run_q != 6'h3f} : 6'h00;
    end
  end
  sequence s_bad;
    pfd_cycle && ce && !power_down_bit_q && !good;
  endsequence
  sequence s_quiet;
    !latch_enable [*6];
  endsequence
  AST_LOCK_COUNT: assert property ($rose(lock_detect_q) |->
    run_q == (lock_cycle_count_select_q ? 6'h05 : 6'h28))
    else $error("lock rose after a wrong run length");
  AST_LOCK_DROP: assert property (s_bad |=> !lock_detect_q)
    else $error("lock kept after a bad comparison");
  AST_LOCK_HOLD: assert property (lock_detect_q && !pfd_cycle
    ##1 !power_down_bit_q |-> lock_detect_q)
    else $error("lock lost without cause");
  AST_PD_LOCK: assert property (power_down_bit_q [*2] |->
    !lock_detect_q)
    else $error("lock high in power-down");
  AST_PD_FORCE: assert property (power_down_bit_q |->
    cp_three_state_q && counter_reset_q && !output_buffer_enable_q)
    else $error("power-down side effects missing");
  AST_DITHER: assert property (
    dither_enable_q == (noise_mode_q == LOW_SPUR_CODE))
    else $error("dither does not follow noise mode");
  AST_CRST_REF: assert property (counter_reset_q [*2] |->
    !pfd_reference_q)
    else $error("reference pulse while counters reset");
  AST_HOLD: assert property (s_quiet |=> $stable(r_count_q) &&
    $stable(fraction_modulus_q) && $stable(noise_mode_q))
    else $error("register output changed without a write");
endmodule

bind pll_synth_config_regs pll_synth_config_regs_monitor #(
  .LOW_SPUR_CODE(LOW_SPUR_CODE)
) u_monitor (
  .ref_clk, .rst, .ce, .latch_enable, .pfd_cycle, .phase_error_ns,
  .fraction_modulus_q, .noise_mode_q, .dither_enable_q, .r_count_q,
  .lock_cycle_count_select_q, .lock_window_select_q, .power_down_bit_q,
  .cp_three_state_q, .counter_reset_q, .output_buffer_enable_q,
  .pfd_reference_q, .lock_detect_q
);
`default_nettype wire

/* bench/serial_host_model.sv */
// behavioural host shifting one word and strobing the latch
// assumes the device samples data on the rising link clock
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  input wire logic go,
  input wire logic [31:0] word,
  output logic serial_clk,
  output logic serial_data,
  output logic latch_enable,
  output logic done
);
  // idle: link clock stands still
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_enable = 1'b0;
    done = 1'b1;
  end
  // one frame: 32 bits msb first at 12 ns, then a long latch
  always @(posedge go) begin
    done = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      serial_data = word[i];
      #6 serial_clk = 1'b1;
      #6 serial_clk = 1'b0;
    end
    serial_data = ~word[0]; // released line shows no stale bit
    latch_enable = 1'b1;
    #200 latch_enable = 1'b0;
    #100 done = 1'b1;
  end
endmodule
`default_nettype wire

/* bench/test_pll_synth_config_regs.sv */
// self-checking bench of the synthesizer configuration registers
// assumes the serial host model and the bound port checker
`timescale 1ns/10ps
`default_nettype none
module test_pll_synth_config_regs;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic pfd_cycle = 1'b0;
  logic ref_rise = 1'b0;
  logic ref_fall = 1'b0;
  logic go = 1'b0;
  logic [7:0] phase_error_ns = 8'h00;
  logic [31:0] word = 32'h0;
  logic [31:0] seed = 32'h2b7d;
  logic [31:0] l1 = 32'h0, l2 = 32'h0, l3 = 32'h0;
  logic [31:0] a1 = 32'h0, a2 = 32'h4000;
  logic [11:0] fr = 12'h0;
  logic [2:0] od = 3'h0, pod = 3'h0;
  logic ce = 1'b1;
  int good = 0, err_total = 0, n_compared = 0, cyc = 0;
  logic serial_clk, serial_data, latch_enable, done;
  logic [11:0] fraction_numerator_q, fraction_modulus_q, phase_word_q;
  logic prescaler_select_q, dither_enable_q, doubler_enable_q;
  logic reference_halver_q, lock_cycle_count_select_q;
  logic lock_window_select_q, power_down_bit_q, cp_three_state_q;
  logic counter_reset_q, boost_enable_q, output_buffer_enable_q;
  logic pfd_reference_q, lock_detect_q;
  logic [1:0] noise_mode_q;
  logic [2:0] test_mux_output_q, cp_current_q, divider_select_q;
  logic [9:0] r_count_q;
  logic [2:0] sels [13] = '{3'h2, 3'h1, 3'h3, 3'h4, 3'h0, 3'h2, 3'h4,
    3'h1, 3'h0, 3'h7, 3'h5, 3'h6, 3'h0};
  wire logic [67:0] got_cfg = {fraction_numerator_q, fraction_modulus_q,
    phase_word_q, prescaler_select_q, noise_mode_q, dither_enable_q,
    test_mux_output_q, doubler_enable_q, reference_halver_q, r_count_q,
    cp_current_q, lock_cycle_count_select_q, lock_window_select_q,
    power_down_bit_q, cp_three_state_q, counter_reset_q, boost_enable_q,
    divider_select_q, output_buffer_enable_q};

  pll_synth_config_regs DUT (.ref_clk, .rst, .ce, .serial_clk,
    .serial_data, .latch_enable, .ref_rise, .ref_fall, .pfd_cycle,
    .phase_error_ns, .fraction_numerator_q, .fraction_modulus_q,
    .phase_word_q, .prescaler_select_q, .noise_mode_q, .dither_enable_q,
    .test_mux_output_q, .doubler_enable_q, .reference_halver_q, .r_count_q,
    .cp_current_q, .lock_cycle_count_select_q, .lock_window_select_q,
    .power_down_bit_q, .cp_three_state_q, .counter_reset_q,
    .boost_enable_q, .divider_select_q, .output_buffer_enable_q,
    .pfd_reference_q, .lock_detect_q);
  serial_host_model u_host (.go, .word, .serial_clk, .serial_data,
    .latch_enable, .done);

  // clock, reference edges and hang limit
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    ref_rise <= cyc % 4 == 0;
    ref_fall <= cyc % 4 == 2;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // expected outputs from the words written so far
  function automatic logic [67:0] expv();
    return {fr, a1[14:3], a1[26:15], l1[27], l2[30:29],
      l2[30:29] == 2'h3, l2[28:26], a2[25:14], l2[11:7], l2[5],
      l2[4] | l2[5], l2[3] | l2[5], l3[18], od, ~l2[5]};
  endfunction
  task automatic cmp_cfg(input logic [67:0] got, input logic [67:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t config %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_lock(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t lock %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmp_ref(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      err_total++;
      $display("[FAIL] %0t reference %0d expected %0d", $time, got, exp);
    end
  endtask
  // one serial word, model update, compare of all outputs but pfd_reference_q and lock_detect_q
  task automatic send(input logic [31:0] w);
    int n;
    @(posedge ref_clk);
    word <= w;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (done !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_total++;
      stop_test();
    end
    case (w[2:0])
      3'h0: begin
        fr = w[14:3];
        a1 = l1;
        a2 = l2;
        if (l2[13]) od = pod;
      end
      3'h1: l1 = w;
      3'h2: begin
        l2 = w;
        if (w[5]) good = 0;
      end
      3'h3: l3 = w;
      3'h4: begin
        pod = w[22:20];
        if (!l2[13]) od = pod;
      end
      default: ;
    endcase
    #1 cmp_cfg(got_cfg, expv());
  endtask
  // one phase detector comparison with the given error
  task automatic pulse(input logic [7:0] e);
    @(posedge ref_clk);
    pfd_cycle <= 1'b1;
    phase_error_ns <= e;
    @(posedge ref_clk);
    pfd_cycle <= 1'b0;
    if (!l2[5] && ce) good = (e < (l2[7] ? 6 : 10)) ? good + 1 : 0;
    #1 cmp_lock(lock_detect_q, good >= (l2[8] ? 5 : 40));
  endtask
  // program R, doubler and halver, apply them, then time the output
  task automatic ref_check(input logic [31:0] w2);
    int r, per, n, t, len, hi;
    logic last;
    r = (w2[23:14] == 10'h000) ? 1 : int'(w2[23:14]);
    per = r * (w2[25] ? 2 : 4) * (w2[24] ? 2 : 1);
    n = 0;
    t = 0;
    len = 0;
    hi = 0;
    last = 1'b1;
    send(w2);
    send(32'h0032_0000);
    if (w2[3]) begin
      repeat (64) begin
        @(posedge ref_clk);
        #1 hi += (pfd_reference_q !== 1'b0);
      end
      cmp_ref(hi, 0);
    end else begin
      while (t < 2 && n < 1000) begin
        @(posedge ref_clk);
        #1 n++;
        if (pfd_reference_q === 1'b1 && !last) t++;
        if (t == 1) begin
          len++;
          hi += (pfd_reference_q !== 1'b0);
        end
        last = pfd_reference_q;
      end
      if (t < 2) begin
        err_total++;
        stop_test();
      end
      cmp_ref(len, per);
      cmp_ref(hi, w2[24] ? per / 2 : 1);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] w;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 cmp_cfg(got_cfg, expv());
    foreach (sels[i]) begin
      seed = xs(seed);
      w = {seed[31:3], sels[i]};
      if (sels[i] == 3'h0) w[30:15] = 16'h0064;
      if (sels[i] == 3'h1) w[3] = 1'b1;
      if (sels[i] == 3'h1) w[26:15] = w[14:3] >> 1;
      if (sels[i] == 3'h2) w[13] = i > 4;
      if (sels[i] == 3'h2) w[5] = i == 5;
      send(w);
    end
    send(32'h0000_4182);
    repeat (4) begin
      seed = xs(seed);
      pulse(seed[7:0] % 8'h06);
    end
    pulse(8'h05);
    pulse(8'h06);
    send(32'h0000_4002);
    repeat (39) begin
      seed = xs(seed);
      pulse(seed[7:0] % 8'h0a);
    end
    pulse(8'h09);
    @(posedge ref_clk);
    ce <= 1'b0;
    pulse(8'hff);
    @(posedge ref_clk);
    ce <= 1'b1;
    send(32'h0000_4022);
    cmp_lock(lock_detect_q, 1'b0);
    pulse(8'h00);
    send(32'h0000_4002);
    pulse(8'h00);
    ref_check(32'h0200_c002);
    ref_check(32'h0101_4002);
    ref_check(32'h0000_c00a);
    stop_test();
  end
endmodule
`default_nettype wire
